// ==== pmc_cfg.sv ====
// Purpose: Address forming, config bytes and on/off sequencing of both channels
// Assumes: Decoded bus commands arrive one per cycle, synchronous to i_clk
// Notes:   Sequence timers are outside; their done levels come in as inputs
`timescale 1ns/1ps
`include "pmc_map.svh"

module pmc_cfg (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_cmd_valid,
  input  wire logic [6:0] i_cmd_addr,
  input  wire logic       i_cmd_write,
  input  wire logic [7:0] i_cmd_code,
  input  wire logic       i_cmd_has_data,
  input  wire logic [7:0] i_cmd_data,
  input  wire logic       i_cmd_pec_ok,
  input  wire logic [7:0] i_bus_rd_data,
  input  wire logic [3:0] i_addr_select_low_pin,
  input  wire logic       i_addr_select_low_open,
  input  wire logic [3:0] i_addr_select_high_pin,
  input  wire logic       i_addr_select_high_open,
  input  wire logic [1:0] i_run,
  input  wire logic       i_shared_sync_clock_line,
  input  wire logic [1:0] i_fault_pin_low,
  input  wire logic [1:0] i_turnon_delay_state_done,
  input  wire logic [1:0] i_turnoff_delay_state_done,
  input  wire logic [1:0] i_toff_ramp_done,
  input  wire logic [1:0] i_min_off_done,
  input  wire logic [1:0] i_vout_decayed,
  output logic            o_addr_ack,
  output logic            o_rd_valid,
  output logic [7:0]      o_rd_data,
  output logic [1:0]      o_ch_tristate,
  output logic [1:0]      o_ch_ramp_down,
  output logic [1:0]      o_min_off_start,
  output logic [1:0]      o_run_pull_low,
  output logic [1:0]      o_short_cycle_status,
  output logic            o_comms_fault,
  output logic            o_alert_n,
  output logic            o_clear_faults,
  output logic            o_nvm_reload,
  output logic            o_fault_log_en,
  output logic            o_ignore_resistor_config_pins,
  output logic            o_mask_proto,
  output logic            o_sync_out_dis,
  output logic            o_bus_timeout_en,
  output logic            o_stretch_en
);

  pmc_pkg::pmc_state_s cur;
  pmc_pkg::pmc_state_s n;
  logic [1:0]          cmd_on;
  logic [6:0]          eff_addr;
  logic                page_ch;
  logic                rail_hit;
  logic                dev_hit;
  logic                bc_hit;
  logic                acc_rst;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic ch_on(input logic [7:0] op, input logic [7:0] oo,
                                 input logic run);
    ch_on = run & (oo[`PMC_OO_USEOP] ? op[`PMC_OP_ONBIT] : 1'b1);
  endfunction

  function automatic logic onoff_ok(input logic [7:0] v);
    onoff_ok = (v == `PMC_ONOFF_V0) || (v == `PMC_ONOFF_V1) ||
               (v == `PMC_ONOFF_V2) || (v == `PMC_ONOFF_V3);
  endfunction

  function automatic logic oper_ok(input logic [7:0] v);
    oper_ok = (v == `PMC_OP_MHI) || (v == `PMC_OP_MLO) || (v == `PMC_OP_ON) ||
              (v == `PMC_OP_SOFT) || (v == `PMC_OP_IMM);
  endfunction

  // ----------------------------------------------------------------------
  // Address forming
  // ----------------------------------------------------------------------
  always_comb begin
    // Open pin takes its field (bits 3:0 low, bits 6:4 high) from the stored address
    eff_addr[3:0] = i_addr_select_low_open ? cur.addr[3:0] : i_addr_select_low_pin;
    eff_addr[6:4] = i_addr_select_high_open ? cur.addr[6:4] : i_addr_select_high_pin[2:0];
    page_ch  = (cur.page == `PMC_PAGE_CH1);
    rail_hit = (cur.rail[page_ch] != `PMC_ADDR_OFF) &&
               (i_cmd_addr == cur.rail[page_ch][6:0]);
    dev_hit  = (cur.addr != `PMC_ADDR_OFF) && (i_cmd_addr == eff_addr);
    bc_hit   = (i_cmd_addr == `PMC_BCAST0) || (i_cmd_addr == `PMC_BCAST1);
    acc_rst  = i_cmd_valid & (dev_hit | bc_hit | rail_hit) & i_cmd_write & ~i_cmd_has_data &
               (i_cmd_code == `PMC_CMD_RESET) & (~cur.gcfg[`PMC_GC_PEC] | i_cmd_pec_ok);
    cmd_on[0] = ch_on(cur.oper[0], cur.onoff[0], i_run[0]);
    cmd_on[1] = ch_on(cur.oper[1], cur.onoff[1], i_run[1]);
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic       hit;
    logic       acc;
    logic       clr;
    logic       set_fault;
    logic       kill;
    logic       imm;
    logic [1:0] tgt;
    logic [7:0] rsel;
    hit       = 1'b0;
    acc       = 1'b0;
    clr       = 1'b0;
    set_fault = 1'b0;
    kill      = 1'b0;
    imm       = 1'b0;
    tgt       = 2'b00;
    rsel      = `PMC_ZERO8;
    n = cur;
    n.ack        = 1'b0;
    n.rd_valid   = 1'b0;
    n.clr_faults = 1'b0;
    n.nvm_reload = 1'b0;
    n.min_start  = 2'b00;
    n.run_low    = 2'b00;
    n.rail_rd    = 1'b0;
    n.run_q      = i_run;

    // Bus contention check in the cycle a rail read answer is driven
    if (cur.rail_rd && (i_bus_rd_data != cur.rd_data)) begin
      set_fault = 1'b1;
    end

    hit = i_cmd_valid & (dev_hit | bc_hit | rail_hit);
    n.ack = hit;
    // Writes with bad PEC dropped when global bit 2 is set
    acc = hit & i_cmd_write & (~cur.gcfg[`PMC_GC_PEC] | i_cmd_pec_ok);
    if (hit && i_cmd_write && cur.gcfg[`PMC_GC_PEC] && !i_cmd_pec_ok) begin
      set_fault = 1'b1;
    end
    if (rail_hit && !dev_hit && !bc_hit) begin
      tgt = page_ch ? 2'b10 : 2'b01;
    end else if (cur.page == `PMC_PAGE_ALL) begin
      tgt = 2'b11;
    end else begin
      tgt = page_ch ? 2'b10 : 2'b01;
    end

    // Faults cleared by command or by a run rising edge
    if (acc && i_cmd_code == `PMC_CMD_CLRF && !i_cmd_has_data) begin
      clr = 1'b1;
    end
    if (cur.gcfg[`PMC_GC_RUNCLR] && |(i_run & ~cur.run_q)) begin
      clr = 1'b1;
    end

    // Register writes
    if (acc && i_cmd_has_data) begin
      case (i_cmd_code)
        `PMC_CMD_PAGE: n.page = i_cmd_data;
        `PMC_CMD_GCFG: n.gcfg = i_cmd_data;
        `PMC_CMD_ADDR: n.addr = i_cmd_data;
        default: ;
      endcase
      for (int c = 0; c < 2; c++) begin
        if (tgt[c]) begin
          case (i_cmd_code)
            `PMC_CMD_OPER: begin
              if (oper_ok(i_cmd_data)) n.oper[c] = i_cmd_data;
              else set_fault = 1'b1;
            end
            `PMC_CMD_ONOFF: begin
              if (onoff_ok(i_cmd_data)) n.onoff[c] = i_cmd_data;
              else set_fault = 1'b1;
            end
            `PMC_CMD_CHCFG: n.chcfg[c] = i_cmd_data;
            `PMC_CMD_RAIL:  n.rail[c] = i_cmd_data;
            default: ;
          endcase
        end
      end
    end

    // Reads answer from channel 0 when both pages are selected
    if (hit && !i_cmd_write) begin
      case (i_cmd_code)
        `PMC_CMD_PAGE:  rsel = cur.page;
        `PMC_CMD_OPER:  rsel = cur.oper[tgt[1] & ~tgt[0]];
        `PMC_CMD_ONOFF: rsel = cur.onoff[tgt[1] & ~tgt[0]];
        `PMC_CMD_CHCFG: rsel = cur.chcfg[tgt[1] & ~tgt[0]];
        `PMC_CMD_GCFG:  rsel = cur.gcfg;
        `PMC_CMD_ADDR:  rsel = cur.addr;
        `PMC_CMD_RAIL:  rsel = cur.rail[tgt[1] & ~tgt[0]];
        default:        rsel = `PMC_ZERO8;
      endcase
      n.rd_valid = 1'b1;
      n.rd_data  = rsel;
      n.rail_rd  = rail_hit & ~dev_hit & ~bc_hit;
    end

    // Channel sequencing; a status bit set here wins over a clear, but not over the reset command
    if (clr) n.status_sc = 2'b00;
    for (int c = 0; c < 2; c++) begin
      kill = cur.chcfg[c][`PMC_CC_SHCLK] & ~i_shared_sync_clock_line;
      imm  = cur.onoff[c][`PMC_OO_IMM] |
             (cur.onoff[c][`PMC_OO_USEOP] & (cur.oper[c] == `PMC_OP_IMM));
      case (cur.st[c])
        pmc_pkg::PMC_OFF: begin
          n.tristate[c] = 1'b1;
          if (cmd_on[c] && !kill) n.st[c] = pmc_pkg::PMC_TON_DLY;
        end
        pmc_pkg::PMC_TON_DLY: begin
          if (!cmd_on[c] || kill) begin
            n.st[c] = pmc_pkg::PMC_OFF;
          end else if (i_turnon_delay_state_done[c]) begin
            n.st[c]       = pmc_pkg::PMC_ON;
            n.tristate[c] = 1'b0;
          end
        end
        pmc_pkg::PMC_ON: begin
          if (kill || !cmd_on[c]) begin
            n.run_low[c] = ~kill & ~cur.chcfg[c][`PMC_CC_NORUNLOW];
            if (kill || imm) begin
              n.tristate[c]  = 1'b1;
              n.min_start[c] = 1'b1;
              n.st[c]        = pmc_pkg::PMC_MIN_OFF;
            end else begin
              n.st[c] = pmc_pkg::PMC_TOFF_DLY;
            end
          end
        end
        pmc_pkg::PMC_TOFF_DLY: begin
          if (cmd_on[c] && cur.chcfg[c][`PMC_CC_SHORT]) begin
            n.tristate[c]   = 1'b1;
            n.min_start[c]  = 1'b1;
            n.short_pend[c] = 1'b1;
            n.st[c]         = pmc_pkg::PMC_MIN_OFF;
          end else if (i_turnoff_delay_state_done[c]) begin
            n.ramp_dn[c] = 1'b1;
            n.st[c]      = pmc_pkg::PMC_TOFF_RMP;
          end
        end
        pmc_pkg::PMC_TOFF_RMP: begin
          if ((cmd_on[c] && cur.chcfg[c][`PMC_CC_SHORT]) || i_toff_ramp_done[c]) begin
            // Ramp stops and output floats together
            n.ramp_dn[c]    = 1'b0;
            n.tristate[c]   = 1'b1;
            n.min_start[c]  = 1'b1;
            n.short_pend[c] = cmd_on[c] & cur.chcfg[c][`PMC_CC_SHORT];
            n.st[c]         = pmc_pkg::PMC_MIN_OFF;
          end
        end
        pmc_pkg::PMC_MIN_OFF: begin
          if (i_min_off_done[c] &&
              (cur.chcfg[c][`PMC_CC_NODECAY] || i_vout_decayed[c])) begin
            n.short_pend[c] = 1'b0;
            if (cur.short_pend[c]) begin
              n.status_sc[c] = 1'b1;
              n.st[c]        = pmc_pkg::PMC_TON_DLY;
            end else begin
              n.st[c] = pmc_pkg::PMC_OFF;
            end
          end
        end
        default: n.st[c] = pmc_pkg::PMC_OFF;
      endcase
    end

    // Reset command: send byte, channels off, reload, clear faults
    if (acc && i_cmd_code == `PMC_CMD_RESET && !i_cmd_has_data) begin
      n.oper       = {`PMC_RST_OPER, `PMC_RST_OPER};
      n.onoff      = {`PMC_RST_ONOFF, `PMC_RST_ONOFF};
      n.chcfg      = {`PMC_RST_CHCFG, `PMC_RST_CHCFG};
      n.rail       = {`PMC_RST_RAIL, `PMC_RST_RAIL};
      n.gcfg       = `PMC_RST_GCFG;
      n.addr       = `PMC_RST_ADDR;
      n.page       = `PMC_RST_PAGE;
      n.st         = '{pmc_pkg::PMC_OFF, pmc_pkg::PMC_OFF};
      n.status_sc  = 2'b00;
      n.tristate   = 2'b11;
      n.ramp_dn    = 2'b00;
      n.short_pend = 2'b00;
      n.nvm_reload = 1'b1;
      clr          = 1'b1;
      set_fault    = 1'b0;
    end

    // Clear first so a new fault in the same cycle survives a clear, but not the reset command
    if (clr) begin
      n.comms      = 1'b0;
      n.clr_faults = 1'b1;
    end
    if (set_fault) n.comms = 1'b1;
    n.alert_n = ~(n.comms | |(i_fault_pin_low &
                 ~{cur.chcfg[1][`PMC_CC_NOALERT], cur.chcfg[0][`PMC_CC_NOALERT]}));
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cur            <= '0;
      cur.oper       <= {`PMC_RST_OPER, `PMC_RST_OPER};
      cur.onoff      <= {`PMC_RST_ONOFF, `PMC_RST_ONOFF};
      cur.chcfg      <= {`PMC_RST_CHCFG, `PMC_RST_CHCFG};
      cur.rail       <= {`PMC_RST_RAIL, `PMC_RST_RAIL};
      cur.gcfg       <= `PMC_RST_GCFG;
      cur.addr       <= `PMC_RST_ADDR;
      cur.page       <= `PMC_RST_PAGE;
      cur.st         <= '{pmc_pkg::PMC_OFF, pmc_pkg::PMC_OFF};
      cur.tristate   <= 2'b11;
      cur.alert_n    <= 1'b1;
    end else begin
      cur <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_addr_ack           = cur.ack;
  assign o_rd_valid           = cur.rd_valid;
  assign o_rd_data            = cur.rd_data;
  assign o_ch_tristate        = cur.tristate;
  assign o_ch_ramp_down       = cur.ramp_dn;
  assign o_min_off_start      = cur.min_start;
  assign o_run_pull_low       = cur.run_low;
  assign o_short_cycle_status = cur.status_sc;
  assign o_comms_fault        = cur.comms;
  assign o_alert_n            = cur.alert_n;
  assign o_clear_faults       = cur.clr_faults;
  assign o_nvm_reload         = cur.nvm_reload;
  assign o_fault_log_en       = cur.gcfg[`PMC_GC_LOG];
  assign o_ignore_resistor_config_pins     = cur.gcfg[`PMC_GC_IGN];
  assign o_mask_proto         = cur.gcfg[`PMC_GC_MASK];
  assign o_sync_out_dis       = cur.gcfg[`PMC_GC_NOSYNC];
  assign o_bus_timeout_en     = cur.gcfg[`PMC_GC_TMO];
  assign o_stretch_en         = cur.gcfg[`PMC_GC_STRETCH];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_short_dly;
    cur.st[0] == pmc_pkg::PMC_TOFF_DLY && cmd_on[0] && cur.chcfg[0][`PMC_CC_SHORT];
  endsequence
  sequence s_minoff_end;
    cur.st[0] == pmc_pkg::PMC_MIN_OFF && i_min_off_done[0] && cur.short_pend[0] &&
    (cur.chcfg[0][`PMC_CC_NODECAY] || i_vout_decayed[0]) && !acc_rst;
  endsequence

  broadcast_ack_a: assert property (i_cmd_valid && i_cmd_addr == `PMC_BCAST0
    |=> o_addr_ack) else $error("broadcast address not answered");
  addr_disable_a: assert property (i_cmd_valid && cur.addr == `PMC_ADDR_OFF &&
    !bc_hit && !rail_hit |=> !o_addr_ack) else $error("disabled address answered");
  short_delay_a: assert property (s_short_dly |=> o_ch_tristate[0] && o_min_off_start[0]
    ##1 !o_min_off_start[0]) else $error("short cycle in delay mishandled");
  short_status_a: assert property (s_minoff_end |=> o_short_cycle_status[0] &&
    cur.st[0] == pmc_pkg::PMC_TON_DLY) else $error("short cycle status missing");
  no_short_a: assert property (cur.st[0] == pmc_pkg::PMC_TOFF_DLY &&
    !cur.chcfg[0][`PMC_CC_SHORT] && !i_turnoff_delay_state_done[0] && !(acc_rst)
    |=> cur.st[0] == pmc_pkg::PMC_TOFF_DLY) else $error("turn-off delay cut short");
  decay_wait_a: assert property (cur.st[0] == pmc_pkg::PMC_MIN_OFF &&
    !cur.chcfg[0][`PMC_CC_NODECAY] && !i_vout_decayed[0] && !acc_rst
    |=> cur.st[0] == pmc_pkg::PMC_MIN_OFF) else $error("left min-off before decay");
  reset_cmd_a: assert property (acc_rst |=> o_nvm_reload && !o_comms_fault &&
    o_ch_tristate == 2'b11) else $error("reset command incomplete");
  run_clear_a: assert property (cur.gcfg[`PMC_GC_RUNCLR] && i_run[0] && !cur.run_q[0]
    |=> o_clear_faults) else $error("run edge did not clear faults");
  bad_onoff_a: assert property (i_cmd_valid && dev_hit && i_cmd_write &&
    i_cmd_has_data && i_cmd_code == `PMC_CMD_ONOFF && !onoff_ok(i_cmd_data)
    |=> o_comms_fault) else $error("bad on/off value not faulted");

endmodule

// ==== pmc_map.svh ====
// Purpose: Command codes, reset values and bit positions of the config block
// Assumes: Included by the config block
// Notes:   Definitions only
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define PMC_CMD_PAGE     8'h00
`define PMC_CMD_OPER     8'h01
`define PMC_CMD_ONOFF    8'h02
`define PMC_CMD_CLRF     8'h03
`define PMC_CMD_CHCFG    8'hD0
`define PMC_CMD_GCFG     8'hD1
`define PMC_CMD_ADDR     8'hE6
`define PMC_CMD_RAIL     8'hFA
`define PMC_CMD_RESET    8'hFD

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PMC_RST_OPER     8'h80
`define PMC_RST_ONOFF    8'h1E
`define PMC_RST_CHCFG    8'h10
`define PMC_RST_GCFG     8'h21
`define PMC_RST_ADDR     8'h4F
`define PMC_RST_RAIL     8'h80
`define PMC_RST_PAGE     8'h00

// ----------------------------------------------------------------------
// Addresses and special values
// ----------------------------------------------------------------------
`define PMC_ADDR_OFF     8'h80
`define PMC_BCAST0       7'h5A
`define PMC_BCAST1       7'h5B
`define PMC_PAGE_ALL     8'hFF
`define PMC_PAGE_CH1     8'h01
`define PMC_ONOFF_V0     8'h1F
`define PMC_ONOFF_V1     8'h1E
`define PMC_ONOFF_V2     8'h17
`define PMC_ONOFF_V3     8'h16
`define PMC_OP_MHI       8'hA8
`define PMC_OP_MLO       8'h98
`define PMC_OP_ON        8'h80
`define PMC_OP_SOFT      8'h40
`define PMC_OP_IMM       8'h00
`define PMC_ZERO8        8'h00

// ----------------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------------
`define PMC_CC_NORUNLOW  4
`define PMC_CC_SHORT     3
`define PMC_CC_SHCLK     2
`define PMC_CC_NOALERT   1
`define PMC_CC_NODECAY   0
`define PMC_GC_LOG       7
`define PMC_GC_IGN       6
`define PMC_GC_MASK      5
`define PMC_GC_NOSYNC    4
`define PMC_GC_TMO       3
`define PMC_GC_PEC       2
`define PMC_GC_STRETCH   1
`define PMC_GC_RUNCLR    0
`define PMC_OO_USEOP     3
`define PMC_OO_IMM       0
`define PMC_OP_ONBIT     7

`endif

// ==== pmc_pkg.sv ====
// Purpose: Types of the config block
// Assumes: pmc_map.svh holds the numbers
// Notes:   Channel states are Gray coded along the usual path from PMC_OFF to PMC_MIN_OFF
package pmc_pkg;

  typedef enum logic [2:0] {
    PMC_OFF      = 3'h0,
    PMC_TON_DLY  = 3'h1,
    PMC_ON       = 3'h3,
    PMC_TOFF_DLY = 3'h2,
    PMC_TOFF_RMP = 3'h6,
    PMC_MIN_OFF  = 3'h7
  } pmc_st_e;

  typedef struct packed {
    logic [1:0][7:0] oper;
    logic [1:0][7:0] onoff;
    logic [1:0][7:0] chcfg;
    logic [1:0][7:0] rail;
    logic [7:0]      gcfg;
    logic [7:0]      addr;
    logic [7:0]      page;
    pmc_st_e [1:0]   st;
    logic [1:0]      short_pend;
    logic [1:0]      status_sc;
    logic [1:0]      tristate;
    logic [1:0]      ramp_dn;
    logic [1:0]      run_low;
    logic [1:0]      min_start;
    logic [1:0]      run_q;
    logic            comms;
    logic            alert_n;
    logic            clr_faults;
    logic            nvm_reload;
    logic            ack;
    logic            rd_valid;
    logic [7:0]      rd_data;
    logic            rail_rd;
  } pmc_state_s;

endpackage

// ==== pmc_host.sv ====
// Purpose: Host model that issues decoded bus transactions
// Assumes: Requests change at the falling edge of i_clk
// Notes:   Bus byte echoes a read answer, otherwise shows its inverse
`timescale 1ns/1ps
module pmc_host (
  input  wire logic       i_clk,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data,
  output logic            o_cmd_valid,
  output logic [6:0]      o_cmd_addr,
  output logic            o_cmd_write,
  output logic [7:0]      o_cmd_code,
  output logic            o_cmd_has_data,
  output logic [7:0]      o_cmd_data,
  output logic            o_cmd_pec_ok,
  output logic [7:0]      o_bus_rd_data
);
  initial begin
    {o_cmd_valid, o_cmd_addr, o_cmd_write, o_cmd_code} = '0;
    {o_cmd_has_data, o_cmd_data, o_cmd_pec_ok} = '0;
  end
  // Bus shows the answer while it stands, its inverse once released
  always_comb begin
    o_bus_rd_data = i_rd_valid ? i_rd_data : ~i_rd_data;
  end
  // One transaction, held for one edge; reads never go to the rail address
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] c,
                      input logic hd, input logic [7:0] d, input logic p);
    @(negedge i_clk);
    {o_cmd_valid, o_cmd_addr, o_cmd_write, o_cmd_code} = {1'b1, a, w, c};
    {o_cmd_has_data, o_cmd_data, o_cmd_pec_ok} = {hd, d, p};
    @(negedge i_clk);
    o_cmd_valid = 1'b0;
  endtask
endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench of the config block
// Assumes: Inputs change at the falling edge; answers sampled one cycle on
// Notes:   Sequence timer done levels are driven by the scenarios
`timescale 1ns/1ps
module testbench;
  logic       i_clk = 1'b0, i_resetn = 1'b0;
  logic [3:0] i_addr_select_low_pin = 4'h0, i_addr_select_high_pin = 4'h0;
  logic       i_addr_select_low_open = 1'b1, i_addr_select_high_open = 1'b1;
  logic [1:0] i_run = 2'h0, i_turnon_delay_state_done = 2'h3, i_min_off_done = 2'h3;
  logic [1:0] i_vout_decayed = 2'h3, i_fault_pin_low = 2'h0, i_turnoff_delay_state_done = 2'h0;
  logic [1:0] i_toff_ramp_done = 2'h0, o_ch_ramp_down, o_run_pull_low;
  logic       i_shared_sync_clock_line = 1'b1, o_alert_n, o_clear_faults;
  logic       i_cmd_valid, i_cmd_write, i_cmd_has_data, i_cmd_pec_ok;
  logic [6:0] i_cmd_addr;
  logic [7:0] i_cmd_code, i_cmd_data, i_bus_rd_data, o_rd_data;
  logic       o_addr_ack, o_rd_valid, o_comms_fault, o_nvm_reload, o_fault_log_en;
  logic       o_ignore_resistor_config_pins, o_mask_proto, o_sync_out_dis, o_bus_timeout_en, o_stretch_en;
  logic [1:0] o_ch_tristate, o_min_off_start, o_short_cycle_status;
  logic [7:0] gcfg_out, vals [4];
  int         bad_count = 0, checked = 0;
  always #12.5 i_clk = ~i_clk;
  assign gcfg_out = {o_fault_log_en, o_ignore_resistor_config_pins, o_mask_proto, o_sync_out_dis,
                     o_bus_timeout_en, 1'b0, o_stretch_en, 1'b0};
  pmc_host u_host (.i_clk, .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data),
    .o_cmd_valid(i_cmd_valid), .o_cmd_addr(i_cmd_addr), .o_cmd_write(i_cmd_write),
    .o_cmd_code(i_cmd_code), .o_cmd_has_data(i_cmd_has_data), .o_cmd_data(i_cmd_data),
    .o_cmd_pec_ok(i_cmd_pec_ok), .o_bus_rd_data(i_bus_rd_data));
  pmc_cfg u_pmc_cfg (.i_clk, .i_resetn, .i_cmd_valid, .i_cmd_addr, .i_cmd_write,
    .i_cmd_code, .i_cmd_has_data, .i_cmd_data, .i_cmd_pec_ok, .i_bus_rd_data,
    .i_addr_select_low_pin, .i_addr_select_low_open, .i_addr_select_high_pin,
    .i_addr_select_high_open, .i_run, .i_shared_sync_clock_line,
    .i_fault_pin_low, .i_turnon_delay_state_done, .i_turnoff_delay_state_done,
    .i_toff_ramp_done, .i_min_off_done, .i_vout_decayed, .o_addr_ack, .o_rd_valid,
    .o_rd_data, .o_ch_tristate, .o_ch_ramp_down, .o_min_off_start, .o_run_pull_low,
    .o_short_cycle_status, .o_comms_fault, .o_alert_n, .o_clear_faults, .o_nvm_reload,
    .o_fault_log_en, .o_ignore_resistor_config_pins, .o_mask_proto, .o_sync_out_dis, .o_bus_timeout_en,
    .o_stretch_en);
  task automatic tally_and_finish;
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
    u_host.xfer(a, 1'b1, c, 1'b1, d, 1'b1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic [7:0] e);
    u_host.xfer(a, 1'b0, c, 1'b0, 8'h00, 1'b1);
    chk8("rd_data", e, o_rd_data);
  endtask
  task automatic ack_at(input logic [6:0] a, input logic e);
    u_host.xfer(a, 1'b0, 8'hD1, 1'b0, 8'h00, 1'b1);
    chk1("addr_ack", e, o_addr_ack);
  endtask
  // Waits for min-off start (0) or short-cycle status (1) of channel 0
  task automatic wait_for(input int w);
    for (int k = 0; k < 50; k++) begin
      if ((w == 0 ? o_min_off_start[0] : o_short_cycle_status[0]) === 1'b1) begin
        return;
      end
      @(negedge i_clk);
    end
    chk1("wait_done", 1'b1, 1'b0);
    tally_and_finish;
  endtask
  initial begin
    repeat (12) @(negedge i_clk);
    i_resetn = 1'b1;
    rd(7'h4F, 8'hD1, 8'h21);
    rd(7'h4F, 8'hD0, 8'h10);
    chk8("gcfg_out", 8'h20, gcfg_out);
    ack_at(7'h4F, 1'b1);
    ack_at(7'h5B, 1'b1);
    i_addr_select_low_open = 1'b0;
    i_addr_select_low_pin = 4'h3;
    ack_at(7'h43, 1'b1);
    ack_at(7'h4F, 1'b0);
    {i_addr_select_high_open, i_addr_select_high_pin, i_addr_select_low_pin} = {1'b0, 8'h25};
    ack_at(7'h25, 1'b1);
    {i_addr_select_low_open, i_addr_select_high_open} = 2'h3;
    wr(7'h5A, 8'hE6, 8'h80);
    ack_at(7'h4F, 1'b0);
    ack_at(7'h5A, 1'b1);
    wr(7'h5A, 8'hE6, 8'h4F);
    wr(7'h5A, 8'hD1, 8'hFE);
    chk8("gcfg_out", 8'hFA, gcfg_out);
    u_host.xfer(7'h5A, 1'b1, 8'hD1, 1'b1, 8'h00, 1'b0);
    rd(7'h5A, 8'hD1, 8'hFE);
    chk1("comms", 1'b1, o_comms_fault);
    u_host.xfer(7'h5A, 1'b1, 8'hFD, 1'b0, 8'h00, 1'b1);
    chk1("nvm_reload", 1'b1, o_nvm_reload);
    rd(7'h4F, 8'hD1, 8'h21);
    chk1("comms", 1'b0, o_comms_fault);
    vals = '{8'h1F, 8'h17, 8'h16, 8'h1E};
    foreach (vals[k]) begin
      wr(7'h4F, 8'h02, vals[k]);
      rd(7'h4F, 8'h02, vals[k]);
    end
    wr(7'h4F, 8'h02, 8'h55);
    rd(7'h4F, 8'h02, 8'h1E);
    chk1("comms", 1'b1, o_comms_fault);
    vals = '{8'hA8, 8'h98, 8'h40, 8'h00};
    foreach (vals[k]) begin
      wr(7'h4F, 8'h01, vals[k]);
      rd(7'h4F, 8'h01, vals[k]);
    end
    wr(7'h4F, 8'h01, 8'h80);
    wr(7'h4F, 8'h01, 8'h11);
    rd(7'h4F, 8'h01, 8'h80);
    wr(7'h4F, 8'hD0, 8'h18);
    i_run = 2'h1;
    repeat (4) @(negedge i_clk);
    chk1("tristate", 1'b0, o_ch_tristate[0]);
    i_run = 2'h0;
    repeat (3) @(negedge i_clk);
    i_run = 2'h1;
    wait_for(0);
    chk1("tristate", 1'b1, o_ch_tristate[0]);
    wait_for(1);
    chk1("status", 1'b1, o_short_cycle_status[0]);
    chk1("comms", 1'b0, o_comms_fault);
    wr(7'h4F, 8'hD0, 8'h08);
    {i_run, i_vout_decayed, i_turnoff_delay_state_done} = 6'h01;
    @(negedge i_clk);
    chk1("run_low", 1'b1, o_run_pull_low[0]);
    @(negedge i_clk);
    chk1("ramp", 1'b1, o_ch_ramp_down[0]);
    i_run = 2'h1;
    @(negedge i_clk);
    chk1("ramp", 1'b0, o_ch_ramp_down[0]);
    chk1("tristate", 1'b1, o_ch_tristate[0]);
    chk1("clear", 1'b1, o_clear_faults);
    repeat (3) @(negedge i_clk);
    chk1("status", 1'b0, o_short_cycle_status[0]);
    i_vout_decayed = 2'h3;
    wait_for(1);
    chk1("status", 1'b1, o_short_cycle_status[0]);
    i_turnoff_delay_state_done = 2'h0;
    wr(7'h4F, 8'hD0, 8'h10);
    i_run = 2'h0;
    @(negedge i_clk);
    chk1("run_low", 1'b0, o_run_pull_low[0]);
    i_run = 2'h1;
    repeat (3) @(negedge i_clk);
    chk1("ramp", 1'b0, o_ch_ramp_down[0]);
    chk1("tristate", 1'b0, o_ch_tristate[0]);
    i_turnoff_delay_state_done = 2'h1;
    @(negedge i_clk);
    chk1("ramp", 1'b1, o_ch_ramp_down[0]);
    i_toff_ramp_done = 2'h1;
    repeat (4) @(negedge i_clk);
    chk1("status", 1'b0, o_short_cycle_status[0]);
    wr(7'h30, 8'hD0, 8'h14);
    rd(7'h4F, 8'hD0, 8'h10);
    wr(7'h4F, 8'hFA, 8'h30);
    wr(7'h30, 8'hD0, 8'h14);
    rd(7'h4F, 8'hD0, 8'h14);
    i_shared_sync_clock_line = 1'b0;
    @(negedge i_clk);
    chk1("tristate", 1'b1, o_ch_tristate[0]);
    i_fault_pin_low = 2'h1;
    repeat (2) @(negedge i_clk);
    chk1("tristate", 1'b1, o_ch_tristate[0]);
    chk1("alert_n", 1'b0, o_alert_n);
    wr(7'h4F, 8'hD0, 8'h16);
    @(negedge i_clk);
    chk1("alert_n", 1'b1, o_alert_n);
    tally_and_finish;
  end
endmodule
